// ---- hdl/pif_top.sv ----
/*
   Peripheral interrupt flag and enable block: third request flag register,
   three enable registers, gating control, event status/mask and a classic
   Wishbone slave. Assumes event pulses from peripherals on CORE_CLK and a
   core that does vectoring and priority arbitration.
*/
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module pif_top
(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [pif_pkg::ADDR_W-1:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic SYNC_SERIAL_B_DONE,
   input wire logic SYNC_SERIAL_B_COLLISION,
   input wire logic ASYNC_B_RX_LOAD,
   input wire logic ASYNC_B_RX_BUFFER_READ,
   input wire logic ASYNC_B_TX_DRAINED,
   input wire logic ASYNC_B_TX_BUFFER_WRITE,
   input wire logic [7:0] TIMER_FOUR_COUNT,
   input wire logic [7:0] TIMER_FOUR_PERIOD,
   input wire pif_pkg::pif_cc_mode_t [pif_pkg::CC_CHANNELS-1:0] CAPCMP_MODE,
   input wire logic [pif_pkg::CC_CHANNELS-1:0] CAPCMP_CAPTURE,
   input wire logic [pif_pkg::CC_CHANNELS-1:0] CAPCMP_MATCH,
   input wire logic [7:0] FLAGS_1,
   input wire logic [7:0] FLAGS_2,
   output logic PERIPH_REQ,
   output logic CORE_REQ,
   output logic PRIORITY_LEVELS_ON,
   output logic IRQ
);
   import pif_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic ack_ff;
   logic [31:0] dat_ff;
   logic [31:0] nxt_dat;
   logic bus_req;
   logic wr_stb;
   logic wr_flags_3;
   logic [7:0] wr_byte;
   logic [7:0] flags_3;
   logic [7:0] flag_set;
   logic [7:0] flag_hw_clr;
   logic [7:0] enable_1_ff;
   logic [7:0] enable_2_ff;
   logic [7:0] enable_3_ff;
   logic [7:0] reset_ctrl_ff;
   logic [7:0] irq_ctrl_ff;
   logic [7:0] evt_status_ff;
   logic [7:0] evt_mask_ff;
   logic t4_equal_ff;
   logic t4_equal;
   logic req_any;
   logic periph_req_ff;
   logic core_req_ff;
   logic priority_on_ff;
   logic irq_ff;
   logic priority_levels_on;
   logic peripheral_irq_gate;
   logic global_irq_gate;

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------

   // Request decode; ack is a single-cycle pulse one edge after the strobe
   assign bus_req = WB_CYC_I && WB_STB_I && !ack_ff;
   assign wr_stb = bus_req && WB_WE_I && WB_SEL_I[0];
   assign wr_byte = WB_DAT_I[7:0];
   assign wr_flags_3 = wr_stb && (WB_ADR_I == OFS_FLAGS_3);

   // Acknowledge every request, mapped or not
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         ack_ff <= 1'b0;
      else
         ack_ff <= bus_req;
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb
   begin
      nxt_dat = 32'h0000_0000;
      unique case (WB_ADR_I)
         OFS_FLAGS_3: nxt_dat[7:0] = flags_3;
         OFS_ENABLE_1: nxt_dat[7:0] = enable_1_ff;
         OFS_ENABLE_2: nxt_dat[7:0] = enable_2_ff & ENABLE_2_MASK;
         OFS_ENABLE_3: nxt_dat[7:0] = enable_3_ff;
         OFS_RESET_CTRL: nxt_dat[7:0] = reset_ctrl_ff;
         OFS_IRQ_CTRL: nxt_dat[7:0] = irq_ctrl_ff;
         OFS_EVT_STATUS: nxt_dat[7:0] = evt_status_ff;
         OFS_EVT_MASK: nxt_dat[7:0] = evt_mask_ff;
         default: nxt_dat = 32'h0000_0000;
      endcase
   end

   // Read data captured on the acknowledge edge
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         dat_ff <= 32'h0000_0000;
      else if (bus_req && !WB_WE_I)
         dat_ff <= nxt_dat;
   end

   assign WB_ACK_O = ack_ff;
   assign WB_DAT_O = dat_ff;

   // ----------------------------------------------------------------
   // Flag sources
   // ----------------------------------------------------------------

   // Timer four match detected on the rising edge of equality
   assign t4_equal = (TIMER_FOUR_COUNT == TIMER_FOUR_PERIOD);

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         t4_equal_ff <= 1'b0;
      else
         t4_equal_ff <= t4_equal;
   end

   assign flag_set[FLG_SYNC_DONE] = SYNC_SERIAL_B_DONE;
   assign flag_set[FLG_SYNC_COLL] = SYNC_SERIAL_B_COLLISION;
   assign flag_set[FLG_RX_FULL] = ASYNC_B_RX_LOAD;
   assign flag_set[FLG_TX_EMPTY] = ASYNC_B_TX_DRAINED;
   assign flag_set[FLG_T4_MATCH] = t4_equal && !t4_equal_ff;

   // Side-effect clears from buffer accesses
   always_comb
   begin
      flag_hw_clr = 8'h00;
      flag_hw_clr[FLG_RX_FULL] = ASYNC_B_RX_BUFFER_READ;
      flag_hw_clr[FLG_TX_EMPTY] = ASYNC_B_TX_BUFFER_WRITE;
   end

   for (genvar c = 0; c < CC_CHANNELS; c++)
   begin : g_cc
      pif_cc_gate u_gate
      (
         .mode(CAPCMP_MODE[c]),
         .capture(CAPCMP_CAPTURE[c]),
         .match(CAPCMP_MATCH[c]),
         .set_flag(flag_set[FLG_CC_C + c])
      );
   end

   for (genvar b = 0; b < 8; b++)
   begin : g_flag
      pif_flag_cell #(.SW_WRITABLE(b != FLG_RX_FULL)) u_cell
      (
         .clk(CORE_CLK),
         .rst(RST),
         .hw_set(flag_set[b]),
         .hw_clr(flag_hw_clr[b]),
         .sw_we(wr_flags_3),
         .sw_d(wr_byte[b]),
         .flag_ff(flags_3[b])
      );
   end

   // ----------------------------------------------------------------
   // Enable and control registers
   // ----------------------------------------------------------------

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         enable_1_ff <= RST_ENABLE;
         enable_2_ff <= RST_ENABLE;
         enable_3_ff <= RST_ENABLE;
      end
      else if (wr_stb)
      begin
         if (WB_ADR_I == OFS_ENABLE_1)
            enable_1_ff <= wr_byte & ENABLE_1_MASK;
         if (WB_ADR_I == OFS_ENABLE_2)
            enable_2_ff <= wr_byte & ENABLE_2_MASK;
         if (WB_ADR_I == OFS_ENABLE_3)
            enable_3_ff <= wr_byte & ENABLE_3_MASK;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         reset_ctrl_ff <= RST_CTRL;
      else if (wr_stb && (WB_ADR_I == OFS_RESET_CTRL))
         reset_ctrl_ff <= {wr_byte[CTL_PRIORITY_ON], 7'h00};
   end

   // Global and peripheral gate bits
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         irq_ctrl_ff <= RST_CTRL;
      else if (wr_stb && (WB_ADR_I == OFS_IRQ_CTRL))
         irq_ctrl_ff <= {wr_byte[CTL_GLOBAL_GATE], wr_byte[CTL_PERIPH_GATE], 6'h00};
   end

   assign priority_levels_on = reset_ctrl_ff[CTL_PRIORITY_ON];
   assign global_irq_gate = irq_ctrl_ff[CTL_GLOBAL_GATE];
   assign peripheral_irq_gate = irq_ctrl_ff[CTL_PERIPH_GATE];

   // ----------------------------------------------------------------
   // Request outputs
   // ----------------------------------------------------------------

   assign req_any = |(flags_3 & enable_3_ff) || |(FLAGS_1 & enable_1_ff)
      || |(FLAGS_2 & enable_2_ff & ENABLE_2_MASK);

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         periph_req_ff <= 1'b0;
         core_req_ff <= 1'b0;
         priority_on_ff <= 1'b0;
      end
      else
      begin
         periph_req_ff <= req_any;
         core_req_ff <= req_any && global_irq_gate && (priority_levels_on || peripheral_irq_gate);
         priority_on_ff <= priority_levels_on;
      end
   end

   assign PERIPH_REQ = periph_req_ff;
   assign CORE_REQ = core_req_ff;
   assign PRIORITY_LEVELS_ON = priority_on_ff;

   // ----------------------------------------------------------------
   // Event status, mask and interrupt line
   // ----------------------------------------------------------------

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         evt_status_ff <= RST_FLAGS;
      else if (wr_stb && (WB_ADR_I == OFS_EVT_STATUS))
         evt_status_ff <= (evt_status_ff & ~wr_byte) | flag_set;
      else
         evt_status_ff <= evt_status_ff | flag_set;
   end

   // Mask register and level interrupt
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         evt_mask_ff <= RST_FLAGS;
         irq_ff <= 1'b0;
      end
      else
      begin
         if (wr_stb && (WB_ADR_I == OFS_EVT_MASK))
            evt_mask_ff <= wr_byte;
         irq_ff <= |(evt_status_ff & evt_mask_ff);
      end
   end

   assign IRQ = irq_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   done_set_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      SYNC_SERIAL_B_DONE |=> flags_3[FLG_SYNC_DONE])
      else $error("serial done flag not set");

   coll_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (flags_3[FLG_SYNC_COLL] && !wr_flags_3) |=> flags_3[FLG_SYNC_COLL])
      else $error("collision flag dropped without software");

   rx_readonly_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (wr_flags_3 && !ASYNC_B_RX_LOAD && !ASYNC_B_RX_BUFFER_READ) |=> $stable(flags_3[FLG_RX_FULL]))
      else $error("receive flag changed by software write");

   tx_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (ASYNC_B_TX_BUFFER_WRITE && !ASYNC_B_TX_DRAINED) |=> !flags_3[FLG_TX_EMPTY])
      else $error("transmit flag not cleared by buffer write");

   t4_match_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      $rose(t4_equal) |-> ##1 flags_3[FLG_T4_MATCH])
      else $error("timer four match flag not set");

   cc_capture_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (CAPCMP_MODE[0] == CC_CAPTURE && CAPCMP_CAPTURE[0]) |=> flags_3[FLG_CC_C])
      else $error("capture did not set channel flag");

   cc_compare_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (CAPCMP_MODE[1] == CC_COMPARE && CAPCMP_MATCH[1]) |=> flags_3[FLG_CC_D])
      else $error("compare match did not set channel flag");

   cc_pwm_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (CAPCMP_MODE[2] == CC_PWM && !wr_flags_3 && !flags_3[FLG_CC_E]) |=> !flags_3[FLG_CC_E])
      else $error("PWM mode set channel flag");

   core_gate_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      $rose(CORE_REQ) |-> $past(peripheral_irq_gate || priority_levels_on))
      else $error("core request without peripheral gate");

   en2_bit4_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      wr_stb && WB_ADR_I == OFS_ENABLE_2 |=> !enable_2_ff[4])
      else $error("unimplemented enable bit stored");

   prio_bit_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (wr_stb && WB_ADR_I == OFS_RESET_CTRL) |-> ##2 PRIORITY_LEVELS_ON == $past(wr_byte[7], 2))
      else $error("priority enable not from bit 7");

   req_and_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (|(flags_3 & enable_3_ff)) |=> PERIPH_REQ)
      else $error("peripheral request missing");

   ack_pulse_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
endmodule

// ---- hdl/pif_pkg.sv ----
/*
   Constants and types for the peripheral interrupt flag and enable block.
   Assumes an 8-bit byte address on a classic Wishbone slave with 32-bit data.
*/
package pif_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_FLAGS_3 = 8'h00;
   localparam logic [7:0] OFS_ENABLE_1 = 8'h04;
   localparam logic [7:0] OFS_ENABLE_2 = 8'h08;
   localparam logic [7:0] OFS_ENABLE_3 = 8'h0c;
   localparam logic [7:0] OFS_RESET_CTRL = 8'h10;
   localparam logic [7:0] OFS_IRQ_CTRL = 8'h14;
   localparam logic [7:0] OFS_EVT_STATUS = 8'h18;
   localparam logic [7:0] OFS_EVT_MASK = 8'h1c;

   // ----------------------------------------------------------------
   // Reset values and implemented-bit masks
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] ENABLE_1_MASK = 8'hff;
   localparam logic [7:0] ENABLE_2_MASK = 8'hef;
   localparam logic [7:0] ENABLE_3_MASK = 8'hff;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int FLG_SYNC_DONE = 7;
   localparam int FLG_SYNC_COLL = 6;
   localparam int FLG_RX_FULL = 5;
   localparam int FLG_TX_EMPTY = 4;
   localparam int FLG_T4_MATCH = 3;
   localparam int FLG_CC_E = 2;
   localparam int FLG_CC_D = 1;
   localparam int FLG_CC_C = 0;
   localparam int CTL_PRIORITY_ON = 7;
   localparam int CTL_GLOBAL_GATE = 7;
   localparam int CTL_PERIPH_GATE = 6;
   localparam int CC_CHANNELS = 3;

   // Capture/compare channel operating mode
   typedef enum logic [1:0]
   {
      CC_OFF = 2'b00,
      CC_CAPTURE = 2'b01,
      CC_COMPARE = 2'b10,
      CC_PWM = 2'b11
   } pif_cc_mode_t;

endpackage

// ---- hdl/pif_flag_cell.sv ----
/*
   One sticky interrupt flag bit with hardware set, hardware clear and an
   optional software write port. Assumes single-cycle event pulses on core clock.
*/
`timescale 1ns/10ps
module pif_flag_cell
#(
   parameter bit SW_WRITABLE = 1'b1
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hw_set,
   input wire logic hw_clr,
   input wire logic sw_we,
   input wire logic sw_d,
   output logic flag_ff
);
   logic nxt_flag;

   // Priority: hardware set, then hardware clear, then software write
   always_comb
   begin
      nxt_flag = flag_ff;
      if (SW_WRITABLE && sw_we)
         nxt_flag = sw_d;
      if (hw_clr)
         nxt_flag = 1'b0;
      if (hw_set)
         nxt_flag = 1'b1;
   end

   // Flag storage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         flag_ff <= 1'b0;
      else
         flag_ff <= nxt_flag;
   end
endmodule

// ---- hdl/pif_cc_gate.sv ----
/*
   Mode gate for one capture/compare channel: turns capture and match pulses
   into a flag set pulse. Assumes all inputs on the core clock.
*/
`timescale 1ns/10ps
module pif_cc_gate
(
   input wire pif_pkg::pif_cc_mode_t mode,
   input wire logic capture,
   input wire logic match,
   output logic set_flag
);
   import pif_pkg::*;

   // Capture and compare set the flag; PWM and off never do
   always_comb
   begin
      unique case (mode)
         CC_CAPTURE: set_flag = capture;
         CC_COMPARE: set_flag = match;
         CC_PWM: set_flag = 1'b0;
         CC_OFF: set_flag = 1'b0;
      endcase
   end
endmodule

// ---- tb/pif_periph_model.sv ----
/*
   Far-side model: peripheral event sources, timer four, capture/compare
   channels and the two external flag registers. Assumes the core clock.
*/
`timescale 1ns/10ps
module pif_periph_model
(
   input wire logic clk,
   output logic [5:0] ev,
   output logic [7:0] t4_count,
   output logic [7:0] t4_period,
   output pif_pkg::pif_cc_mode_t [pif_pkg::CC_CHANNELS-1:0] cc_mode,
   output logic [pif_pkg::CC_CHANNELS-1:0] cc_capture,
   output logic [pif_pkg::CC_CHANNELS-1:0] cc_match,
   output logic [7:0] flags_1,
   output logic [7:0] flags_2
);
   import pif_pkg::*;

   // Quiet sources; period out of reach of a stopped count
   initial
   begin
      ev = 6'h00;
      t4_count = 8'h00;
      t4_period = 8'hff;
      cc_mode = '{CC_OFF, CC_OFF, CC_OFF};
      cc_capture = 3'h0;
      cc_match = 3'h0;
      flags_1 = 8'h00;
      flags_2 = 8'h00;
   end

   // One-cycle event pulse; bits: done, coll, rx load, rx read, tx drained, tx write
   task automatic pulse(input logic [5:0] bits);
      ev <= bits;
      @(posedge clk);
      ev <= 6'h00;
      @(posedge clk);
   endtask

   // Timer four counts up through its period, then stops away from it
   task automatic run_timer(input logic [7:0] per);
      t4_period <= per;
      for (int i = 0; i <= int'(per) + 2; i++)
      begin
         t4_count <= 8'(i);
         @(posedge clk);
      end
      t4_count <= 8'h00;
      @(posedge clk);
   endtask

   // Channel mode change followed by a capture and/or match pulse
   task automatic cc_event(input int ch, input pif_cc_mode_t m, input logic cap, input logic mat);
      cc_mode[ch] <= m;
      @(posedge clk);
      cc_capture[ch] <= cap;
      cc_match[ch] <= mat;
      @(posedge clk);
      cc_capture <= 3'h0;
      cc_match <= 3'h0;
      cc_mode[ch] <= CC_OFF;
      @(posedge clk);
   endtask

   // External flag register levels
   task automatic set_flags(input logic [7:0] f1, input logic [7:0] f2);
      flags_1 <= f1;
      flags_2 <= f2;
      @(posedge clk);
   endtask
endmodule

// ---- tb/tb_top.sv ----
/*
   Self-checking bench for the peripheral interrupt flag and enable block.
   Assumes the far-side model and a Wishbone master built from tasks here.
*/
`timescale 1ns/10ps
module tb_top;
   import pif_pkg::*;

   logic clk, rst, cyc, stb, we, preq, creq, prio, irq, ack;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat, dat_o;
   logic [5:0] ev;
   logic [7:0] t4c, t4p, f1, f2, q;
   pif_cc_mode_t [CC_CHANNELS-1:0] ccm;
   logic [CC_CHANNELS-1:0] cap, mat;
   int n_errors = 0;
   int samples_checked = 0;

   pif_periph_model pif_periph_model_inst (.clk(clk), .ev(ev), .t4_count(t4c), .t4_period(t4p),
      .cc_mode(ccm), .cc_capture(cap), .cc_match(mat), .flags_1(f1), .flags_2(f2));

   pif_top pif_top_inst (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .SYNC_SERIAL_B_DONE(ev[5]), .SYNC_SERIAL_B_COLLISION(ev[4]), .ASYNC_B_RX_LOAD(ev[3]),
      .ASYNC_B_RX_BUFFER_READ(ev[2]), .ASYNC_B_TX_DRAINED(ev[1]), .ASYNC_B_TX_BUFFER_WRITE(ev[0]),
      .TIMER_FOUR_COUNT(t4c), .TIMER_FOUR_PERIOD(t4p), .CAPCMP_MODE(ccm), .CAPCMP_CAPTURE(cap),
      .CAPCMP_MATCH(mat), .FLAGS_1(f1), .FLAGS_2(f2), .PERIPH_REQ(preq), .CORE_REQ(creq),
      .PRIORITY_LEVELS_ON(prio), .IRQ(irq));

   // ----------------------------------------------------------------
   // Free-running clock
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   // One classic cycle; holds the request until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h000000, d};
      do
      begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50)
         n_errors++;
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Read a register and compare it
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      wb(1'b0, a, 8'h00);
      chk8($sformatf("reg_%h", a), exp, q);
   endtask

   // Let flags and request outputs settle, then compare outputs
   task automatic outs(input logic [2:0] exp);
      repeat (3) @(posedge clk);
      chk8("preq_creq_irq", {5'h00, exp}, {5'h00, preq, creq, irq});
   endtask

   task automatic summarize;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      summarize;
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      {cyc, stb, we} = 3'b000;
      adr = 8'h00;
      sel = 4'hf;
      dat = 32'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(OFS_FLAGS_3, 8'h00);
      rd(OFS_ENABLE_1, 8'h00);
      rd(OFS_ENABLE_2, 8'h00);
      outs(3'b000);
      // Enable registers, unimplemented bit and an unmapped place
      wb(1'b1, OFS_ENABLE_1, 8'hff);
      rd(OFS_ENABLE_1, 8'hff);
      wb(1'b1, OFS_ENABLE_1, 8'h5a);
      rd(OFS_ENABLE_1, 8'h5a);
      // A write without its low byte lane selected is ignored
      sel <= 4'he;
      wb(1'b1, OFS_ENABLE_1, 8'h33);
      sel <= 4'hf;
      rd(OFS_ENABLE_1, 8'h5a);
      wb(1'b1, OFS_ENABLE_2, 8'hff);
      rd(OFS_ENABLE_2, 8'hef);
      wb(1'b1, OFS_ENABLE_2, 8'h10);
      rd(OFS_ENABLE_2, 8'h00);
      wb(1'b1, OFS_ENABLE_2, 8'he0);
      rd(OFS_ENABLE_2, 8'he0);
      wb(1'b1, OFS_ENABLE_2, 8'h0f);
      rd(OFS_ENABLE_2, 8'h0f);
      wb(1'b1, 8'h20, 8'hff);
      rd(8'h20, 8'h00);
      // Event flags with enable 3 still clear
      pif_periph_model_inst.pulse(6'b110010);
      rd(OFS_FLAGS_3, 8'hd0);
      wb(1'b1, OFS_FLAGS_3, 8'h00);
      rd(OFS_FLAGS_3, 8'h00);
      pif_periph_model_inst.pulse(6'b001000);
      wb(1'b1, OFS_FLAGS_3, 8'h00);
      rd(OFS_FLAGS_3, 8'h20);
      pif_periph_model_inst.pulse(6'b000100);
      rd(OFS_FLAGS_3, 8'h00);
      // Load and buffer read in one cycle: the set wins
      pif_periph_model_inst.pulse(6'b001100);
      rd(OFS_FLAGS_3, 8'h20);
      pif_periph_model_inst.pulse(6'b000100);
      // Software may set every flag but the read-only receive bit
      wb(1'b1, OFS_FLAGS_3, 8'hff);
      rd(OFS_FLAGS_3, 8'hdf);
      wb(1'b1, OFS_FLAGS_3, 8'h00);
      rd(OFS_FLAGS_3, 8'h00);
      pif_periph_model_inst.pulse(6'b000010);
      rd(OFS_FLAGS_3, 8'h10);
      pif_periph_model_inst.pulse(6'b000001);
      rd(OFS_FLAGS_3, 8'h00);
      pif_periph_model_inst.run_timer(8'h05);
      rd(OFS_FLAGS_3, 8'h08);
      wb(1'b1, OFS_FLAGS_3, 8'h00);
      // Each channel in capture, compare and PWM mode
      for (int ch = 0; ch < CC_CHANNELS; ch++)
      begin
         pif_periph_model_inst.cc_event(ch, CC_CAPTURE, 1'b1, 1'b0);
         rd(OFS_FLAGS_3, 8'(1 << ch));
         wb(1'b1, OFS_FLAGS_3, 8'h00);
         pif_periph_model_inst.cc_event(ch, CC_COMPARE, 1'b0, 1'b1);
         rd(OFS_FLAGS_3, 8'(1 << ch));
         wb(1'b1, OFS_FLAGS_3, 8'h00);
         pif_periph_model_inst.cc_event(ch, CC_PWM, 1'b1, 1'b1);
         rd(OFS_FLAGS_3, 8'h00);
      end
      // Request path and the two gate bits
      wb(1'b1, OFS_ENABLE_1, 8'h00);
      wb(1'b1, OFS_ENABLE_2, 8'h00);
      wb(1'b1, OFS_FLAGS_3, 8'h00);
      wb(1'b1, OFS_ENABLE_3, 8'h80);
      rd(OFS_ENABLE_3, 8'h80);
      wb(1'b1, OFS_IRQ_CTRL, 8'h80);
      pif_periph_model_inst.pulse(6'b100000);
      outs(3'b100);
      wb(1'b1, OFS_IRQ_CTRL, 8'hc0);
      outs(3'b110);
      wb(1'b1, OFS_IRQ_CTRL, 8'h80);
      wb(1'b1, OFS_RESET_CTRL, 8'h80);
      outs(3'b110);
      chk8("prio", 8'h01, {7'h00, prio});
      wb(1'b1, OFS_FLAGS_3, 8'h00);
      outs(3'b000);
      // External flag registers against enables 1 and 2
      wb(1'b1, OFS_ENABLE_1, 8'h01);
      wb(1'b1, OFS_ENABLE_2, 8'hff);
      pif_periph_model_inst.set_flags(8'h01, 8'h00);
      outs(3'b110);
      pif_periph_model_inst.set_flags(8'h00, 8'h10);
      outs(3'b000);
      pif_periph_model_inst.set_flags(8'h00, 8'h01);
      outs(3'b110);
      pif_periph_model_inst.set_flags(8'h00, 8'h00);
      // Event status, mask and write-one-to-clear
      wb(1'b1, OFS_EVT_STATUS, 8'hff);
      wb(1'b1, OFS_EVT_MASK, 8'h00);
      // Done flag stays enabled, so both requests stand throughout
      pif_periph_model_inst.pulse(6'b100000);
      outs(3'b110);
      rd(OFS_EVT_STATUS, 8'h80);
      wb(1'b1, OFS_EVT_MASK, 8'h80);
      outs(3'b111);
      wb(1'b1, OFS_EVT_STATUS, 8'h80);
      outs(3'b110);
      // Reset in mid-run clears flags, enables and requests
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(OFS_FLAGS_3, 8'h00);
      rd(OFS_ENABLE_1, 8'h00);
      rd(OFS_ENABLE_2, 8'h00);
      outs(3'b000);
      summarize;
   end
endmodule
